//--- hw/acc_regs.svh
// address map, reset values and programming codes of the auxiliary control block
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// special function register addresses
`define ACC_SFR_AUX        8'hf1
`define ACC_SFR_PTR_LOW    8'hf2
`define ACC_SFR_PTR_HIGH   8'hf3

// auxiliary control fields
`define ACC_AUX_SEL_BIT    0
`define ACC_AUX_ZERO_BIT   2
`define ACC_AUX_SOFTWARE_RESET_BIT_BIT   3
`define ACC_AUX_KEEP_MASK  8'hf3
`define ACC_AUX_RESET      8'h00
`define ACC_PTR_RESET      16'h0000

// code space areas
`define ACC_SIG_ADDR0      16'hfc30
`define ACC_SIG_ADDR1      16'hfc31
`define ACC_SIG_ADDR2      16'hfc60
`define ACC_CUST_BASE      16'hfce0
`define ACC_CUST_LAST      16'hfcff

// data space configuration bytes
`define ACC_CFG1_ADDR      16'hfd00
`define ACC_CFG2_ADDR      16'hfd01
`define ACC_CFG_UNPROG     8'hff
`define ACC_CFG_WATCHDOG_ENABLE_CONFIG_BIT   7

// serial programming
`define ACC_PCMD_WRITE     8'h01
`define ACC_PCMD_READ      8'h02
`define ACC_PBIT_ADDR_END  5'h17
`define ACC_PBIT_LAST      5'h1f

`endif

//--- hw/acc_pkg.sv
// types of the auxiliary control block
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_PS_IDLE,
    ACC_PS_RECV,
    ACC_PS_SEND
  } acc_prog_e;
  typedef logic [15:0] acc_addr_t;
endpackage

//--- hw/acc_top.sv
// auxiliary control, dual data pointer, signature/customer area and configuration bytes
// Functional notes
// - writing auxiliary control with bit 3 set pulses soft_reset and clears both pointers and auxiliary control
// - two data pointers; the select bit picks the one instructions use
// - the unselected pointer is hidden and keeps its value until a software reset clears it
// - pointer increment adds one to the selected pointer only
// - load immediate writes all sixteen bits into the selected pointer
// - indirect jump and code reads add accumulator to selected pointer
// - pointer byte register accesses reach the selected pointer's bytes
// - bit 2 of auxiliary control reads zero and ignores writes
// - data-memory moves through the pointer reach configuration information
// - signature bytes readable by code reads at fc30h, fc31h, fc60h
// - 32-byte customer area fce0h to fcffh readable as code-read data
// - configuration applied at power up, program can only read it
// - first configuration byte readable by data move at fd00h
// - programmer exchanges commands, addresses and data serially on two pins
// - watchdog enable configuration forces watchdog clock select to zero
`include "acc_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module acc_top
  import acc_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE0 = 8'h5a,  // arbitrary value
  parameter logic [7:0] SIG_BYTE1 = 8'h3c,  // arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'h96,  // arbitrary value
  parameter int         CUST_DEPTH = 32
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // special function register access from the core
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  // data pointer instructions
  input  wire logic        ptr_inc,
  input  wire logic        ptr_load,
  input  wire logic [15:0] ptr_load_val,
  input  wire logic [7:0]  acc_in,
  input  wire logic        code_rd,
  input  wire logic        xdata_rd,
  // read answer and addresses
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  output logic             code_hit,
  output logic [15:0]      ind_addr,
  output logic [15:0]      data_pointer,
  // reset and watchdog
  output logic             soft_reset,
  input  wire logic        watchdog_clock_select_sw,
  output logic             watchdog_clock_select,
  output logic [7:0]       power_up_config_byte_one,
  output logic [7:0]       power_up_config_byte_two,
  // serial programming pins
  input  wire logic        prog_mode,
  input  wire logic        prog_clk_in,
  input  wire logic        prog_dat_in,
  output logic             prog_dat_out,
  output logic             prog_dat_oe
);

  localparam int CIW = $clog2(CUST_DEPTH);

  logic [15:0]     dp0_r, dp0_nxt, dp1_r, dp1_nxt;
  logic [15:0]     data_pointer_r, data_pointer_nxt;
  logic [7:0]      aux_r, aux_nxt;
  logic            software_reset_bit_r, software_reset_bit_nxt;
  logic [7:0]      rdata_r, rdata_nxt;
  logic            rvalid_r, rvalid_nxt, hit_r, hit_nxt;
  logic [15:0]     ind_r, ind_nxt;
  logic            watchdog_clock_select_r, watchdog_clock_select_nxt;
  logic [7:0]      cell1_r, cell1_nxt, cell2_r, cell2_nxt;
  logic [7:0]      cfg1_r, cfg1_nxt, cfg2_r, cfg2_nxt;
  logic            loaded_r, loaded_nxt;
  logic [7:0]      cust_r [CUST_DEPTH];
  logic [7:0]      cust_nxt [CUST_DEPTH];
  acc_prog_e       pst_r, pst_nxt;
  logic [4:0]      pcnt_r, pcnt_nxt;
  logic [31:0]     psh_r, psh_nxt;
  logic [7:0]      pout_r, pout_nxt;
  logic            poe_r, poe_nxt, pclk_d_r;
  logic [15:0]     cur_ptr, upd_ptr, code_addr;
  logic            pedge;

  // code space lookup shared by core reads and the programmer
  function automatic logic [8:0] code_lookup(input acc_addr_t a);
    logic [8:0] r;
    r = 9'h000;
    if (a == `ACC_SIG_ADDR0)
      r = {1'b1, SIG_BYTE0};
    else if (a == `ACC_SIG_ADDR1)
      r = {1'b1, SIG_BYTE1};
    else if (a == `ACC_SIG_ADDR2)
      r = {1'b1, SIG_BYTE2};
    else if (a >= `ACC_CUST_BASE && a <= `ACC_CUST_LAST)
      r = {1'b1, cust_r[a[CIW-1:0]]};
    return r;
  endfunction

  assign cur_ptr   = aux_r[`ACC_AUX_SEL_BIT] ? dp1_r : dp0_r;
  assign code_addr = cur_ptr + {8'h00, acc_in};
  assign pedge     = prog_clk_in & ~pclk_d_r;

  // core side pointers and control
  always_comb
  begin
    dp0_nxt  = dp0_r;
    dp1_nxt  = dp1_r;
    aux_nxt  = aux_r;
    software_reset_bit_nxt = 1'b0;
    upd_ptr  = cur_ptr;
    if (ptr_load)
      upd_ptr = ptr_load_val;
    else if (ptr_inc)
      upd_ptr = cur_ptr + 16'h0001;
    else if (sfr_wr && sfr_addr == `ACC_SFR_PTR_LOW)
      upd_ptr = {cur_ptr[15:8], sfr_wdata};
    else if (sfr_wr && sfr_addr == `ACC_SFR_PTR_HIGH)
      upd_ptr = {sfr_wdata, cur_ptr[7:0]};
    if (aux_r[`ACC_AUX_SEL_BIT])
      dp1_nxt = upd_ptr;
    else
      dp0_nxt = upd_ptr;
    if (sfr_wr && sfr_addr == `ACC_SFR_AUX)
    begin
      aux_nxt  = sfr_wdata & `ACC_AUX_KEEP_MASK;
      software_reset_bit_nxt = sfr_wdata[`ACC_AUX_SOFTWARE_RESET_BIT_BIT];
    end
    if (software_reset_bit_r)
    begin
      dp0_nxt = `ACC_PTR_RESET;
      dp1_nxt = `ACC_PTR_RESET;
      aux_nxt = `ACC_AUX_RESET;
    end
    // registered copy of the pointer that will be selected next cycle
    data_pointer_nxt = aux_nxt[`ACC_AUX_SEL_BIT] ? dp1_nxt : dp0_nxt;
  end

  // read answers
  always_comb
  begin
    rdata_nxt  = 8'h00;
    hit_nxt    = 1'b0;
    rvalid_nxt = sfr_rd | code_rd | xdata_rd;
    ind_nxt    = code_addr;
    if (sfr_rd)
    begin
      if (sfr_addr == `ACC_SFR_AUX)
        rdata_nxt = aux_r & `ACC_AUX_KEEP_MASK;
      else if (sfr_addr == `ACC_SFR_PTR_LOW)
        rdata_nxt = cur_ptr[7:0];
      else if (sfr_addr == `ACC_SFR_PTR_HIGH)
        rdata_nxt = cur_ptr[15:8];
    end
    else if (code_rd)
    begin
      {hit_nxt, rdata_nxt} = code_lookup(code_addr);
    end
    else if (xdata_rd)
    begin
      if (cur_ptr == `ACC_CFG1_ADDR)
        rdata_nxt = cfg1_r;
      else if (cur_ptr == `ACC_CFG2_ADDR)
        rdata_nxt = cfg2_r;
    end
  end

  // configuration capture, watchdog select and serial programming
  always_comb
  begin
    cell1_nxt  = cell1_r;
    cell2_nxt  = cell2_r;
    cust_nxt   = cust_r;
    cfg1_nxt   = cfg1_r;
    cfg2_nxt   = cfg2_r;
    loaded_nxt = 1'b1;
    pst_nxt    = pst_r;
    pcnt_nxt   = pcnt_r;
    psh_nxt    = psh_r;
    pout_nxt   = pout_r;
    poe_nxt    = poe_r;
    // latched once after power-up reset, never by the program
    if (!loaded_r)
    begin
      cfg1_nxt = cell1_r;
      cfg2_nxt = cell2_r;
    end
    watchdog_clock_select_nxt = cfg1_r[`ACC_CFG_WATCHDOG_ENABLE_CONFIG_BIT] ? 1'b0 : watchdog_clock_select_sw;
    // serial exchange on clock and data pins
    if (!prog_mode)
    begin
      pst_nxt  = ACC_PS_IDLE;
      pcnt_nxt = 5'h00;
      poe_nxt  = 1'b0;
    end
    else if (pst_r == ACC_PS_IDLE)
      pst_nxt = ACC_PS_RECV;
    else if (pedge)
    begin
      psh_nxt  = {psh_r[30:0], prog_dat_in};
      pcnt_nxt = pcnt_r + 5'h01;
      case (pst_r)
        ACC_PS_RECV:
        begin
          if (pcnt_r == `ACC_PBIT_ADDR_END && psh_r[22:15] == `ACC_PCMD_READ)
          begin
            pst_nxt = ACC_PS_SEND;
            poe_nxt = 1'b1;
            if (psh_nxt[15:0] == `ACC_CFG1_ADDR)
              pout_nxt = cell1_r;
            else if (psh_nxt[15:0] == `ACC_CFG2_ADDR)
              pout_nxt = cell2_r;
            else
              pout_nxt = 8'(code_lookup(psh_nxt[15:0]));
          end
          else if (pcnt_r == `ACC_PBIT_LAST)
          begin
            if (psh_nxt[31:24] == `ACC_PCMD_WRITE)
            begin
              if (psh_nxt[23:8] == `ACC_CFG1_ADDR)
                cell1_nxt = psh_nxt[7:0];
              else if (psh_nxt[23:8] == `ACC_CFG2_ADDR)
                cell2_nxt = psh_nxt[7:0];
              else if (psh_nxt[23:8] >= `ACC_CUST_BASE && psh_nxt[23:8] <= `ACC_CUST_LAST)
                cust_nxt[psh_nxt[CIW+7:8]] = psh_nxt[7:0];
            end
          end
        end
        ACC_PS_SEND:
        begin
          pout_nxt = {pout_r[6:0], 1'b0};
          if (pcnt_r == `ACC_PBIT_LAST)
          begin
            pst_nxt = ACC_PS_RECV;
            poe_nxt = 1'b0;
          end
        end
        default:
          pst_nxt = ACC_PS_IDLE;
      endcase
    end
  end

  // customer area keeps its contents across software resets
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dp0_r    <= `ACC_PTR_RESET;
      dp1_r    <= `ACC_PTR_RESET;
      data_pointer_r   <= `ACC_PTR_RESET;
      aux_r    <= `ACC_AUX_RESET;
      software_reset_bit_r   <= 1'b0;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
      hit_r    <= 1'b0;
      ind_r    <= 16'h0000;
      watchdog_clock_select_r  <= 1'b0;
      cell1_r  <= `ACC_CFG_UNPROG;
      cell2_r  <= `ACC_CFG_UNPROG;
      cfg1_r   <= `ACC_CFG_UNPROG;
      cfg2_r   <= `ACC_CFG_UNPROG;
      loaded_r <= 1'b0;
      for (int i = 0; i < CUST_DEPTH; i++)
        cust_r[i] <= `ACC_CFG_UNPROG;
      pst_r    <= ACC_PS_IDLE;
      pcnt_r   <= 5'h00;
      psh_r    <= 32'h0000_0000;
      pout_r   <= 8'h00;
      poe_r    <= 1'b0;
      pclk_d_r <= 1'b0;
    end
    else
    begin
      dp0_r    <= dp0_nxt;
      dp1_r    <= dp1_nxt;
      data_pointer_r   <= data_pointer_nxt;
      aux_r    <= aux_nxt;
      software_reset_bit_r   <= software_reset_bit_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      hit_r    <= hit_nxt;
      ind_r    <= ind_nxt;
      watchdog_clock_select_r  <= watchdog_clock_select_nxt;
      cell1_r  <= cell1_nxt;
      cell2_r  <= cell2_nxt;
      cfg1_r   <= cfg1_nxt;
      cfg2_r   <= cfg2_nxt;
      loaded_r <= loaded_nxt;
      cust_r   <= cust_nxt;
      pst_r    <= pst_nxt;
      pcnt_r   <= pcnt_nxt;
      psh_r    <= psh_nxt;
      pout_r   <= pout_nxt;
      poe_r    <= poe_nxt;
      pclk_d_r <= prog_clk_in;
    end
  end

  assign rd_data                  = rdata_r;
  assign rd_valid                 = rvalid_r;
  assign code_hit                 = hit_r;
  assign ind_addr                 = ind_r;
  assign data_pointer             = data_pointer_r;
  assign soft_reset               = software_reset_bit_r;
  assign watchdog_clock_select    = watchdog_clock_select_r;
  assign power_up_config_byte_one = cfg1_r;
  assign power_up_config_byte_two = cfg2_r;
  assign prog_dat_out             = pout_r[7];
  assign prog_dat_oe              = poe_r;

endmodule

`default_nettype wire

//--- tb/acc_top_properties.sv
// port assertions for the auxiliary control block
`timescale 1ns/1ns
`default_nettype none
module acc_top_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // core requests
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        ptr_inc,
  input wire logic        ptr_load,
  input wire logic [15:0] ptr_load_val,
  input wire logic [7:0]  acc_in,
  input wire logic        code_rd,
  input wire logic        xdata_rd,
  input wire logic        watchdog_clock_select_sw,
  // answers
  input wire logic [7:0]  rd_data,
  input wire logic        rd_valid,
  input wire logic [15:0] ind_addr,
  input wire logic [15:0] data_pointer,
  input wire logic        soft_reset,
  input wire logic        watchdog_clock_select,
  input wire logic [7:0]  power_up_config_byte_one
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic calm_r;
  wire logic aux_wr = sfr_wr && sfr_addr == 8'hf1;
  // last cycle was neither reset nor software reset, so last values are meaningful
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      calm_r <= 1'b0;
    else
      calm_r <= !soft_reset;
  a_answer_timing: assert property (calm_r |-> rd_valid == $past(sfr_rd || code_rd || xdata_rd))
    else $error("read answer timing wrong");
  a_soft_reset_pulse: assert property (aux_wr && sfr_wdata[3] && !soft_reset |=> soft_reset ##1
    !soft_reset && data_pointer == 16'h0)
    else $error("software reset not performed");
  a_load_value: assert property (ptr_load && !sfr_wr && !soft_reset |=> data_pointer == $past(ptr_load_val))
    else $error("pointer load wrong");
  a_inc_selected: assert property (ptr_inc && !ptr_load && !sfr_wr && !soft_reset |=>
    data_pointer == $past(data_pointer) + 16'h1)
    else $error("pointer increment wrong");
  a_pointer_hold: assert property (!(ptr_inc || ptr_load || sfr_wr || soft_reset) |=> $stable(data_pointer))
    else $error("pointer changed without cause");
  a_jump_address: assert property (calm_r |-> ind_addr == $past(data_pointer) + {8'h00, $past(acc_in)})
    else $error("indirect address wrong");
  a_aux_zero_bits: assert property (sfr_rd && sfr_addr == 8'hf1 && !soft_reset |=> rd_data[3:2] == 2'b00)
    else $error("aux bits 2 and 3 not zero");
  a_watchdog_forced: assert property (calm_r |-> watchdog_clock_select ==
    ($past(watchdog_clock_select_sw) && !$past(power_up_config_byte_one[7])))
    else $error("watchdog clock select not forced");
  a_config_fixed: assert property (calm_r |-> $stable(power_up_config_byte_one))
    else $error("config byte changed while running");
endmodule
bind acc_top acc_top_checker i_acc_top_checker (.sys_clk, .rst, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata,
  .ptr_inc, .ptr_load, .ptr_load_val, .acc_in, .code_rd, .xdata_rd, .watchdog_clock_select_sw, .rd_data,
  .rd_valid, .ind_addr, .data_pointer, .soft_reset, .watchdog_clock_select, .power_up_config_byte_one);
`default_nettype wire

//--- tb/acc_prog_host.sv
// serial programmer model driving the two programming pins
`timescale 1ns/1ns
`default_nettype none
module acc_prog_host (
  // clock
  input wire logic  sys_clk,
  // programming pins
  output logic      prog_mode,
  output logic      prog_clk_in,
  output logic      prog_dat_in,
  input wire logic  prog_dat_out,
  input wire logic  prog_dat_oe
);
  logic hb = 1'b0;
  initial prog_mode = 1'b0;
  initial prog_clk_in = 1'b0;
  assign prog_dat_in = prog_dat_oe ? prog_dat_out : hb;
  // one frame, msb first; clock stands low between frames
  task automatic frame(input logic [31:0] f, output logic [7:0] q);
    prog_mode = 1'b1;
    repeat (4) @(posedge sys_clk);
    #5;
    for (int i = 31; i >= 0; i--)
    begin
      hb = f[i];
      if (i < 8)
        q[i] = prog_dat_in;
      repeat (3) @(posedge sys_clk);
      #5 prog_clk_in = 1'b1;
      repeat (3) @(posedge sys_clk);
      #5 prog_clk_in = 1'b0;
    end
    prog_mode = 1'b0;
    hb = ~hb;
    @(posedge sys_clk);
    #5;
  endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the auxiliary control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sfr_wr, sfr_rd, ptr_inc, ptr_load, code_rd, xdata_rd, watchdog_clock_select_sw;
  logic [7:0] sfr_addr, sfr_wdata, acc_in, rd_data, power_up_config_byte_one, power_up_config_byte_two;
  logic [15:0] ptr_load_val, ind_addr, data_pointer;
  logic rd_valid, code_hit, soft_reset, watchdog_clock_select;
  logic prog_mode, prog_clk_in, prog_dat_in, prog_dat_out, prog_dat_oe;
  logic [7:0] cust [32];
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 32'h6440;
  always #25 sys_clk = ~sys_clk;
  // signature values are arbitrary
  acc_top #(.SIG_BYTE0(8'ha1), .SIG_BYTE1(8'hb2), .SIG_BYTE2(8'hc3)) i_acc_top (.sys_clk, .rst, .sfr_wr,
    .sfr_rd, .sfr_addr, .sfr_wdata, .ptr_inc, .ptr_load, .ptr_load_val, .acc_in, .code_rd, .xdata_rd,
    .rd_data, .rd_valid, .code_hit, .ind_addr, .data_pointer, .soft_reset, .watchdog_clock_select_sw,
    .watchdog_clock_select, .power_up_config_byte_one, .power_up_config_byte_two, .prog_mode,
    .prog_clk_in, .prog_dat_in, .prog_dat_out, .prog_dat_oe);
  acc_prog_host i_acc_prog_host (.sys_clk, .prog_mode, .prog_clk_in, .prog_dat_in, .prog_dat_out,
    .prog_dat_oe);
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // strobes last one cycle; the answer is settled when this returns
  task automatic tick;
    @(posedge sys_clk);
    #5;
    {sfr_wr, sfr_rd, ptr_inc, ptr_load, code_rd, xdata_rd} = '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    tick;
  endtask
  task automatic ld(input logic [15:0] v);
    {ptr_load, ptr_load_val} = {1'b1, v};
    tick;
  endtask
  function automatic logic [8:0] code_exp(input logic [15:0] a);
    if (a == 16'hfc30) return {1'b1, 8'ha1};
    if (a == 16'hfc31) return {1'b1, 8'hb2};
    if (a == 16'hfc60) return {1'b1, 8'hc3};
    if (a[15:5] == 11'h7e7) return {1'b1, cust[a[4:0]]};
    return 9'h000;
  endfunction
  task automatic cread(input logic [15:0] p, input logic [7:0] a);
    ld(p);
    acc_in = a;
    code_rd = 1'b1;
    tick;
    chk({rd_valid, code_hit, rd_data}, {1'b1, code_exp(p + a)});
    chk(ind_addr, p + a);
  endtask
  task automatic xread(input logic [15:0] p, input logic [7:0] e);
    ld(p);
    xdata_rd = 1'b1;
    tick;
    chk({rd_valid, rd_data}, {1'b1, e});
  endtask
  initial
  begin
    logic [15:0] va, vb;
    logic [7:0] q, d;
    {sfr_wr, sfr_rd, ptr_inc, ptr_load, code_rd, xdata_rd, watchdog_clock_select_sw} = '0;
    {sfr_addr, sfr_wdata, acc_in, ptr_load_val} = '0;
    foreach (cust[i]) cust[i] = 8'hff;
    repeat (8) @(posedge sys_clk);
    #5 rst = 1'b0;
    chk({data_pointer, power_up_config_byte_one}, 24'h0000ff);
    chk(power_up_config_byte_two, 8'hff);
    va = $random(seed);
    vb = $random(seed);
    ld(va);
    wr(8'hf1, 8'h01);
    ld(vb);
    chk(data_pointer, vb);
    {sfr_rd, sfr_addr} = {1'b1, 8'hf2};
    tick;
    chk(rd_data, vb[7:0]);
    wr(8'hf3, va[7:0]);
    chk(data_pointer, {va[7:0], vb[7:0]});
    wr(8'hf1, 8'hf6);
    chk(data_pointer, va);
    ptr_inc = 1'b1;
    tick;
    chk(data_pointer, va + 16'h1);
    {sfr_rd, sfr_addr} = {1'b1, 8'hf1};
    tick;
    chk(rd_data, 8'hf2);
    wr(8'hf1, rd_data + 8'h1);
    chk(data_pointer, {va[7:0], vb[7:0]});
    $display("pointer tests done");
    wr(8'hf1, 8'h09);
    chk(soft_reset, 1'b1);
    tick;
    chk({soft_reset, data_pointer}, 17'h0);
    $display("software reset test done");
    cread(16'hfc00, 8'h30);
    cread(16'hfc31, 8'h00);
    cread(16'hfc5f, 8'h01);
    cread(16'hfd00, 8'h00);
    repeat (4) cread(16'hfce0, $random(seed) & 8'h1f);
    xread(16'hfd00, 8'hff);
    xread(16'hfd01, 8'hff);
    xread(16'h1234, 8'h00);
    d = $random(seed);
    cust[5] = d;
    i_acc_prog_host.frame({8'h01, 16'hfce5, d}, q);
    i_acc_prog_host.frame({8'h01, 16'hfd00, 8'h00}, q);
    i_acc_prog_host.frame({8'h02, 16'hfce5, 8'h00}, q);
    chk(q, d);
    i_acc_prog_host.frame({8'h02, 16'hfd00, 8'h00}, q);
    chk(q, 8'h00);
    chk(prog_dat_oe, 1'b0);
    chk(power_up_config_byte_one, 8'hff);
    xread(16'hfd00, 8'hff);
    cread(16'hfce5, 8'h00);
    watchdog_clock_select_sw = 1'b1;
    tick;
    tick;
    chk(watchdog_clock_select, 1'b0);
    $display("memory and programming tests done");
    report_and_stop;
  end
  // the run needs about 840 cycles; this cuts a hang short
  initial
  begin
    #2000000;
    miscompares++;
    report_and_stop;
  end
endmodule
`default_nettype wire
